//--- src/scm_pkg.sv
// Purpose: constants for the serial clock mux and baud generator
// Assumes: AXI4-Lite with 32-bit data and 8-bit byte addresses
// Notes: each register holds 8 bits in the low byte of a word
package scm_pkg;
  // ==========================================================
  // bus and register map
  localparam int unsigned ADDR_W = 8;  // byte address width
  localparam int unsigned DATA_W = 32; // bus data width
  localparam logic [7:0] OFS_CLK_MODE = 8'h00; // clock_mode_control
  localparam logic [7:0] OFS_TC_LO = 8'h04;    // baud_time_constant_low
  localparam logic [7:0] OFS_TC_HI = 8'h08;    // baud_time_constant_high
  localparam logic [7:0] OFS_MISC = 8'h0c;     // misc_control
  localparam logic [7:0] OFS_STATUS = 8'h10;   // read-only state
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // reset values
  localparam logic [7:0] CLK_MODE_RST = 8'h00;
  localparam logic [7:0] TC_RST = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h00; // brg off, pin source
  // ==========================================================
  // clock_mode_control fields
  localparam int unsigned CM_XTAL_EN = 7;  // crystal oscillator on
  localparam int unsigned CM_RXSEL = 5;    // rx source, 2 bits
  localparam int unsigned CM_TXSEL = 3;    // tx source, 2 bits
  localparam int unsigned CM_BIDIR_OUT = 2; // bidir pin may drive
  localparam int unsigned CM_BIDIR_SEL = 0; // bidir drive select
  // misc_control fields
  localparam int unsigned MISC_BRG_PCLK = 1; // 1: peripheral clock
  localparam int unsigned MISC_BRG_EN = 0;   // generator enable
  // status register fields
  localparam int unsigned ST_ZERO = 0;
  localparam int unsigned ST_BAUD = 1;
  localparam int unsigned ST_RUN = 2;
  localparam int unsigned ST_BIDIR_OE = 3;
  localparam int unsigned ST_SYNC_HUNT = 4;
  // ==========================================================
  // clock source codes for the rx and tx muxes
  localparam logic [1:0] SRC_RTX_PIN = 2'h0;
  localparam logic [1:0] SRC_BIDIR_PIN = 2'h1;
  localparam logic [1:0] SRC_BRG = 2'h2;
  localparam logic [1:0] SRC_DIGITAL_PHASE_LOCKED_LOOP_TX = 2'h3;
  // drive codes for the bidirectional clock pin
  localparam logic [1:0] OUT_XTAL = 2'h0;
  localparam logic [1:0] OUT_BRG = 2'h1;
  localparam logic [1:0] OUT_DIGITAL_PHASE_LOCKED_LOOP_RX = 2'h2;
  localparam logic [1:0] OUT_TX_CLK = 2'h3;
  // ==========================================================
  // baud generator widths
  localparam int unsigned TC_W = 16; // down-counter width
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
endpackage : scm_pkg

//--- src/scm_baud_gen.sv
// Purpose: 16-bit reloading down-counter with divide-by-two output
// Assumes: src_tick marks one rising edge of the chosen source
// Notes: runs on aclk; a tick is one edge of the generator clock
`timescale 1ns/10ps
module scm_baud_gen
  import scm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic src_tick,
  input wire logic [15:0] time_const,
  output logic baud_out,
  output logic zero_count,
  output logic running
);
  // ==========================================================
  // state
  logic en_sync_r;     // enable seen on a generator edge
  logic en_sync_nxt;
  logic [15:0] cnt_r;  // down-counter
  logic [15:0] cnt_nxt;
  logic load_r;        // next tick loads the time constant
  logic load_nxt;
  logic out_r;         // divide-by-two stage
  logic out_nxt;
  logic zero_r;        // zero-count condition
  logic zero_nxt;
  logic run;

  // start waits one generator edge, stop is immediate
  assign run = enable & en_sync_r;

  // ==========================================================
  // next state
  always_comb begin
    en_sync_nxt = en_sync_r;
    cnt_nxt = cnt_r;
    load_nxt = load_r;
    out_nxt = out_r;
    zero_nxt = zero_r; // held while stopped
    if (!enable) begin
      en_sync_nxt = 1'b0; // no sync on the way down
    end else if (src_tick) begin
      en_sync_nxt = 1'b1;
    end
    if (run) begin
      zero_nxt = 1'b0;
      if (src_tick) begin
        if (load_r) begin
          // reload cycle adds one tick: tc+2 per half period
          cnt_nxt = time_const;
          load_nxt = 1'b0;
        end else if (cnt_r == CNT_ZERO) begin
          out_nxt = ~out_r;
          load_nxt = 1'b1;
          zero_nxt = 1'b1;   // one cycle only
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
    end
  end

  // ==========================================================
  // registers; reset forces zero-count active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_sync_r <= 1'b0;
      cnt_r <= CNT_ZERO;
      load_r <= 1'b1;
      out_r <= 1'b0;
      zero_r <= 1'b1;
    end else begin
      en_sync_r <= en_sync_nxt;
      cnt_r <= cnt_nxt;
      load_r <= load_nxt;
      out_r <= out_nxt;
      zero_r <= zero_nxt;
    end
  end

  assign baud_out = out_r;
  assign zero_count = zero_r;
  assign running = run;
endmodule : scm_baud_gen

//--- src/scm_clock_ctrl.sv
// Purpose: clock muxes, crystal control, bidir clock pin, baud gen
// Assumes: pin levels are synchronous to aclk; AXI4-Lite host
// Notes: clock outputs are sampled levels, edges move one aclk late
`timescale 1ns/10ps
module scm_clock_ctrl
  import scm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // pins and neighbour blocks
  input wire logic rx_tx_clock_pin,
  input wire logic xtal_osc_in,
  input wire logic bidir_clock_pin_in,
  output logic bidir_clock_pin_out,
  output logic bidir_clock_pin_oe,
  input wire logic digital_phase_locked_loop_rx_clk,
  input wire logic digital_phase_locked_loop_tx_clk,
  input wire logic async_mode,
  input wire logic sync_pulse_req,
  input wire logic ext_sync_req,
  input wire logic sync_pin_in,
  output logic sync_pin_out,
  output logic sync_pin_oe,
  output logic ext_sync_en,
  output logic sync_hunt,
  output logic xtal_amp_en,
  output logic rx_clock_n,
  output logic rx_sample,
  output logic tx_clock,
  output logic baud_out,
  output logic baud_zero
);
  // ==========================================================
  // helpers
  // four-way clock source mux shared by rx and tx paths
  function automatic logic pick_src(
    input logic [1:0] sel,
    input logic rtx,
    input logic bidir,
    input logic brg,
    input logic digital_phase_locked_loop
  );
    logic res;
    res = rtx;
    case (sel)
      SRC_BIDIR_PIN: res = bidir;
      SRC_BRG: res = brg;
      SRC_DIGITAL_PHASE_LOCKED_LOOP_TX: res = digital_phase_locked_loop;
      default: res = rtx;
    endcase
    return res;
  endfunction : pick_src

  // mapped-address check used by the write channel only
  function automatic logic is_rw_reg(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == OFS_CLK_MODE) begin
      hit = 1'b1;
    end else if (a == OFS_TC_LO) begin
      hit = 1'b1;
    end else if (a == OFS_TC_HI) begin
      hit = 1'b1;
    end else if (a == OFS_MISC) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_rw_reg

  // ==========================================================
  // declarations
  logic [7:0] cm_r, cm_nxt;     // clock_mode_control
  logic [7:0] tcl_r, tcl_nxt;   // baud_time_constant_low
  logic [7:0] tch_r, tch_nxt;   // baud_time_constant_high
  logic [7:0] misc_r, misc_nxt; // misc_control
  logic aw_hold_r, aw_hold_nxt; // address taken, not yet used
  logic w_hold_r, w_hold_nxt;   // data taken, not yet used
  logic [7:0] wa_r, wa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic ws_r, ws_nxt;           // byte lane 0 strobe
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic xtal_on;
  logic rtx_eff;               // rx/tx pin or crystal output
  logic rtx_prev_r;            // last level, for edge detect
  logic brg_tick;
  logic brg_out, brg_zero, brg_run;
  logic rx_src, tx_src;
  logic rx_prev_r;
  logic bidir_sel;             // bidir pin used as a source
  logic rxn_r, rxn_nxt;
  logic rxs_r, rxs_nxt;
  logic txc_r, txc_nxt;
  logic bo_r, bo_nxt;
  logic boe_r, boe_nxt;
  logic so_r, so_nxt;
  logic soe_r, soe_nxt;
  logic es_r, es_nxt;
  logic sh_r, sh_nxt;
  logic xa_r, xa_nxt;
  logic [7:0] status;

  // ==========================================================
  // clock selection
  assign xtal_on = cm_r[CM_XTAL_EN];
  // pin users follow the oscillator while it runs
  assign rtx_eff = xtal_on ? xtal_osc_in : rx_tx_clock_pin;
  // generator clock: peripheral clock ticks every cycle
  // a switch while running may clip a count
  assign brg_tick = misc_r[MISC_BRG_PCLK] | (rtx_eff & ~rtx_prev_r);
  assign rx_src = pick_src(cm_r[CM_RXSEL +: 2], rtx_eff,
    bidir_clock_pin_in, brg_out, digital_phase_locked_loop_tx_clk);
  assign tx_src = pick_src(cm_r[CM_TXSEL +: 2], rtx_eff,
    bidir_clock_pin_in, brg_out, digital_phase_locked_loop_tx_clk);
  assign bidir_sel = (cm_r[CM_RXSEL +: 2] == SRC_BIDIR_PIN) |
    (cm_r[CM_TXSEL +: 2] == SRC_BIDIR_PIN);

  // ==========================================================
  // baud rate generator
  scm_baud_gen u_brg (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(misc_r[MISC_BRG_EN]),
    .src_tick(brg_tick),
    .time_const({tch_r, tcl_r}),
    .baud_out(brg_out),
    .zero_count(brg_zero),
    .running(brg_run)
  );

  // ==========================================================
  // pin and clock outputs
  always_comb begin
    // receiver samples on falling edge of the inverted copy,
    // i.e. on the rising edge of the source
    rxn_nxt = ~rx_src;
    rxs_nxt = rx_src & ~rx_prev_r;
    txc_nxt = tx_src;
    xa_nxt = xtal_on;
    // bidir pin drives only when allowed and not a source
    boe_nxt = cm_r[CM_BIDIR_OUT] & ~bidir_sel;
    case (cm_r[CM_BIDIR_SEL +: 2])
      OUT_XTAL: bo_nxt = xtal_on ? xtal_osc_in : 1'b1;
      OUT_BRG: bo_nxt = brg_out;
      OUT_DIGITAL_PHASE_LOCKED_LOOP_RX: bo_nxt = digital_phase_locked_loop_rx_clk;
      default: bo_nxt = tx_src;         // actual transmit clock
    endcase
    // sync pin belongs to the oscillator while it runs
    es_nxt = ext_sync_req & ~async_mode & ~xtal_on;
    so_nxt = xtal_on ? 1'b0 : sync_pulse_req;
    soe_nxt = ~xtal_on & ~async_mode & ~ext_sync_req;
    // with the crystal on, async sync/hunt stops following the pin
    sh_nxt = (xtal_on & async_mode) ? 1'b0 : sync_pin_in;
  end

  // edge history follows the level through reset too, so a high
  // idle pin gives no false edge or tick right after release
  always_ff @(posedge aclk) begin
    rtx_prev_r <= rtx_eff;
    rx_prev_r <= rx_src;
  end

  // registers the pin outputs; nothing drives before reset ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxn_r <= 1'b1;
      rxs_r <= 1'b0;
      txc_r <= 1'b0;
      xa_r <= 1'b0;
      bo_r <= 1'b1;
      boe_r <= 1'b0;
      es_r <= 1'b0;
      so_r <= 1'b0;
      soe_r <= 1'b0;
      sh_r <= 1'b0;
    end else begin
      rxn_r <= rxn_nxt;
      rxs_r <= rxs_nxt;
      txc_r <= txc_nxt;
      xa_r <= xa_nxt;
      bo_r <= bo_nxt;
      boe_r <= boe_nxt;
      es_r <= es_nxt;
      so_r <= so_nxt;
      soe_r <= soe_nxt;
      sh_r <= sh_nxt;
    end
  end

  // ==========================================================
  // axi4-lite slave: one write and one read at a time
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    cm_nxt = cm_r;
    tcl_nxt = tcl_r;
    tch_nxt = tch_r;
    misc_nxt = misc_r;
    // address and data are taken in either order
    if (awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      wa_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      wd_nxt = wdata;
      ws_nxt = wstrb[0];
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    // both halves held: commit and answer
    if (aw_hold_r && w_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = is_rw_reg(wa_r) ? RESP_OKAY : RESP_SLVERR;
      if (ws_r) begin
        if (wa_r == OFS_CLK_MODE) begin
          cm_nxt = wd_r[7:0];
        end else if (wa_r == OFS_TC_LO) begin
          tcl_nxt = wd_r[7:0]; // low byte
        end else if (wa_r == OFS_TC_HI) begin
          tch_nxt = wd_r[7:0]; // high byte
        end else if (wa_r == OFS_MISC) begin
          misc_nxt = wd_r[7:0];
        end
      end
    end
    // no new halves while one is held or a response waits
    awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
    wready_nxt = ~w_hold_nxt & ~bvalid_nxt;
  end

  // status word: block state visible to software
  assign status = {3'h0, sh_r, boe_r, brg_run, brg_out, brg_zero};

  // read channel: data one cycle after the address is taken
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      if (araddr == OFS_CLK_MODE) begin
        rdata_nxt = {24'h000000, cm_r};
      end else if (araddr == OFS_TC_LO) begin
        rdata_nxt = {24'h000000, tcl_r};
      end else if (araddr == OFS_TC_HI) begin
        rdata_nxt = {24'h000000, tch_r};
      end else if (araddr == OFS_MISC) begin
        rdata_nxt = {24'h000000, misc_r};
      end else if (araddr == OFS_STATUS) begin
        rdata_nxt = {24'h000000, status};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = RESP_SLVERR;
      end
    end
    arready_nxt = ~rvalid_nxt;
  end

  // bus registers; reset stops the generator on the pin clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cm_r <= CLK_MODE_RST;
      tcl_r <= TC_RST;
      tch_r <= TC_RST;
      misc_r <= MISC_RST;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      wa_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      cm_r <= cm_nxt;
      tcl_r <= tcl_nxt;
      tch_r <= tch_nxt;
      misc_r <= misc_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign bidir_clock_pin_out = bo_r;
  assign bidir_clock_pin_oe = boe_r;
  assign sync_pin_out = so_r;
  assign sync_pin_oe = soe_r;
  assign ext_sync_en = es_r;
  assign sync_hunt = sh_r;
  assign xtal_amp_en = xa_r;
  assign rx_clock_n = rxn_r;
  assign rx_sample = rxs_r;
  assign tx_clock = txc_r;
  assign baud_out = brg_out;
  assign baud_zero = brg_zero;

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_xtal_amp_follow: assert property (xtal_on |=> xtal_amp_en)
    else $error("crystal amplifier not enabled");
  a_xtal_feeds_rx: assert property (
    xtal_on && cm_r[CM_RXSEL +: 2] == SRC_RTX_PIN && !$changed(cm_r)
    |=> rx_clock_n == !$past(xtal_osc_in))
    else $error("rx clock not fed by crystal");
  a_sync_pin_quiet: assert property (
    xtal_on && !async_mode |=> !sync_pin_oe && !ext_sync_en)
    else $error("sync pin used while crystal on");
  a_hunt_forced_zero: assert property (
    xtal_on && async_mode |=> !sync_hunt)
    else $error("sync hunt not zero");
  a_rx_from_brg: assert property (
    cm_r[CM_RXSEL +: 2] == SRC_BRG |=> rx_clock_n == !$past(brg_out))
    else $error("rx clock not from generator");
  a_tx_from_digital_phase_locked_loop: assert property (
    cm_r[CM_TXSEL +: 2] == SRC_DIGITAL_PHASE_LOCKED_LOOP_TX |=> tx_clock == $past(digital_phase_locked_loop_tx_clk))
    else $error("tx clock not from digital_phase_locked_loop");
  a_bidir_stays_in: assert property (
    (bidir_sel || !cm_r[CM_BIDIR_OUT]) |=> !bidir_clock_pin_oe)
    else $error("bidir pin driven while input");
  a_bidir_high_idle: assert property (
    !xtal_on && cm_r[CM_BIDIR_SEL +: 2] == OUT_XTAL
    |=> bidir_clock_pin_out)
    else $error("bidir pin not high");
  a_brg_stop_now: assert property (
    !misc_r[MISC_BRG_EN] |-> !brg_run ##1 ($stable(baud_out) && $stable(baud_zero)))
    else $error("generator runs while disabled");
  a_zero_held_stop: assert property (
    !brg_run |=> $stable(baud_zero))
    else $error("zero count moved while stopped");
  a_zero_one_cycle: assert property (
    misc_r[MISC_BRG_PCLK] && brg_run && baud_zero && $past(brg_run)
    |=> !baud_zero)
    else $error("zero count longer than a cycle");
  a_toggle_on_zero: assert property (
    $changed(baud_out) |-> baud_zero)
    else $error("output toggled without zero");

  c_rx_brg: cover property (cm_r[CM_RXSEL +: 2] == SRC_BRG && rx_sample);
  c_bidir_drive: cover property (bidir_clock_pin_oe && bidir_clock_pin_out);
  c_brg_zero: cover property (brg_run && $rose(baud_zero));
endmodule : scm_clock_ctrl

//--- bench/scm_pin_model.sv
// Purpose: far-side clock pin model driving the rx/tx clock pin
// Assumes: driven from aclk; half period counted in aclk cycles
// Notes: the pin stands still at lvl while run is low, as a stopped line
`timescale 1ns/10ps
module scm_pin_model #(
  parameter int HALF = 2 // aclk cycles per pin half period
) (
  input wire logic aclk,
  input wire logic run,
  input wire logic lvl,
  output logic pin_clk
);
  int cnt = 0; // half period counter
  // ==========================================================
  // clock only while running, otherwise a static level
  always @(posedge aclk) begin
    if (!run) begin
      pin_clk <= lvl;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      pin_clk <= ~pin_clk;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : scm_pin_model

//--- bench/tb.sv
// Purpose: self-checking bench for the clock mux and baud generator
// Assumes: 40 ns aclk, sync active-low reset, AXI4-Lite master tasks
// Notes: mux paths use static random levels so one-cycle lag is harmless
`timescale 1ns/10ps
module tb
  import scm_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, xosc = 1'b0, bid_drv = 1'b0, digital_phase_locked_loop_rx = 1'b0, digital_phase_locked_loop_tx = 1'b0, async_m = 1'b0;
  logic sp_in = 1'b0, run = 1'b0, lvl = 1'b0, sp_req = 1'b0, es_req = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pin, bid_out, bid_oe, sp_out, sp_oe, ext_en, hunt;
  logic amp, rxn, rxs, tx_clock_pin, bout, bzero;
  wire logic bid_in = bid_oe ? bid_out : bid_drv; // pin level from both drivers
  int n_mismatch = 0, n_tests = 0, cyc = 0, seed = 32'ha7b1, i, k;
  logic [31:0] r;
  logic [7:0] cm;
  logic [15:0] tc;
  logic e_rx, e_tx, e_oe, e_bo, fl, b0, z0;
  always #20 aclk = ~aclk;
  scm_pin_model #(.HALF(2)) u_pins (.aclk(aclk), .run(run), .lvl(lvl), .pin_clk(pin));
  scm_clock_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .rx_tx_clock_pin(pin),
    .xtal_osc_in(xosc), .bidir_clock_pin_in(bid_in), .bidir_clock_pin_out(bid_out),
    .bidir_clock_pin_oe(bid_oe), .digital_phase_locked_loop_rx_clk(digital_phase_locked_loop_rx), .digital_phase_locked_loop_tx_clk(digital_phase_locked_loop_tx), .async_mode(async_m),
    .sync_pulse_req(sp_req), .ext_sync_req(es_req), .sync_pin_in(sp_in), .sync_pin_out(sp_out),
    .sync_pin_oe(sp_oe), .ext_sync_en(ext_en), .sync_hunt(hunt), .xtal_amp_en(amp), .rx_clock_n(rxn),
    .rx_sample(rxs), .tx_clock(tx_clock_pin), .baud_out(bout), .baud_zero(bzero));
  // ==========================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // sample readies at the falling edge, act on the rising edge, so no race with the slave's flops
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int t;
    logic ag, dg, bg;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'h1; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (t = 0; t < 64; t++) begin
      @(negedge aclk);
      ag = awvalid & awready; dg = wvalid & wready; bg = bvalid;
      @(posedge aclk);
      if (ag) awvalid <= 1'b0;
      if (dg) wvalid <= 1'b0;
      if (bg) begin
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        break;
      end
    end
    if (t == 64) chk(32'h1, 32'h0);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    logic ag, rg;
    logic [31:0] rd;
    logic [1:0] rr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (t = 0; t < 64; t++) begin
      @(negedge aclk);
      ag = arvalid & arready; rg = rvalid; rd = rdata; rr = rresp;
      @(posedge aclk);
      if (ag) arvalid <= 1'b0;
      if (rg) begin
        rready <= 1'b0;
        chk(rd, ed);
        chk({30'h0, rr}, {30'h0, er});
        break;
      end
    end
    if (t == 64) chk(32'h1, 32'h0);
  endtask : axi_rd
  // the interval after the first toggle is steady, whatever count was held while stopped
  task automatic measure(input int exp);
    int c, z;
    logic b;
    @(negedge aclk);
    b = bout;
    for (c = 0; c < 2000 && bout === b; c++) @(negedge aclk);
    b = bout;
    z = 0;
    for (c = 0; c < 2000; c++) begin
      @(negedge aclk);
      z += int'(bzero);
      if (bout !== b) break;
    end
    chk(32'(c + 1), 32'(exp));
    chk(32'(z), 32'h1);
  endtask : measure
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // source mux model: the crystal stands in for the rx/tx pin
  function automatic logic src(input logic [1:0] s, input logic x);
    case (s)
      2'h0: return x ? xosc : lvl;
      2'h1: return bid_in;
      2'h2: return 1'b0; // generator idle since reset
      default: return digital_phase_locked_loop_tx;
    endcase
  endfunction : src
  // ==========================================================
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(bzero, 1'b1);
    chk(bid_oe, 1'b0);
    for (i = 0; i < 4; i++) axi_rd(8'(4 * i), 32'h0, RESP_OKAY);
    axi_rd(OFS_STATUS, 32'h00000001, RESP_OKAY);
    axi_rd(8'h14, 32'h0, RESP_SLVERR);
    axi_wr(OFS_STATUS, 8'h01, RESP_SLVERR);
    axi_wr(8'h14, 8'h01, RESP_SLVERR);
    $display("test reset and map done");
    for (i = 0; i < 32; i++) begin
      r = $random(seed);
      cm = {i[4], i[3:2], i[1:0], r[9], r[8:7]};
      @(posedge aclk);
      lvl <= r[0];
      xosc <= r[1];
      bid_drv <= r[2];
      digital_phase_locked_loop_rx <= r[3];
      digital_phase_locked_loop_tx <= r[4];
      async_m <= r[5];
      sp_in <= r[6];
      sp_req <= r[10];
      es_req <= r[11];
      axi_wr(OFS_CLK_MODE, cm, RESP_OKAY);
      repeat (3) @(negedge aclk);
      e_oe = cm[2] && (cm[6:5] != SRC_BIDIR_PIN) && (cm[4:3] != SRC_BIDIR_PIN);
      e_rx = src(cm[6:5], cm[7]);
      e_tx = src(cm[4:3], cm[7]);
      e_bo = (cm[1:0] == OUT_XTAL) ? (cm[7] ? xosc : 1'b1) : (cm[1:0] == OUT_BRG) ? 1'b0 :
             (cm[1:0] == OUT_DIGITAL_PHASE_LOCKED_LOOP_RX) ? digital_phase_locked_loop_rx : e_tx;
      chk(rxn, {31'h0, ~e_rx});
      chk(tx_clock_pin, e_tx);
      chk(bid_oe, e_oe);
      if (e_oe) chk(bid_out, e_bo);
      chk(amp, cm[7]);
      if (cm[7]) chk({sp_oe, ext_en}, 2'b00);
      chk({sp_out, sp_oe, ext_en}, {~cm[7] & sp_req, ~cm[7] & ~async_m & ~es_req, ~cm[7] & ~async_m & es_req});
      chk(hunt, (cm[7] && async_m) ? 1'b0 : sp_in);
    end
    $display("test clock muxes done");
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      // keep the generator off so its source only moves while stopped
      if (i == 3) r[0] = 1'b0;
      axi_wr(8'(4 * i), r[7:0], RESP_OKAY);
      axi_rd(8'(4 * i), {24'h0, r[7:0]}, RESP_OKAY);
    end
    axi_wr(OFS_CLK_MODE, 8'h00, RESP_OKAY);
    axi_wr(OFS_MISC, 8'h02, RESP_OKAY);
    $display("test register readback done");
    for (k = 0; k < 5; k++) begin
      r = $random(seed);
      tc = (k == 1) ? 16'h0100 : (k == 0) ? 16'h0000 : {11'h0, r[4:0]};
      axi_wr(OFS_TC_LO, tc[7:0], RESP_OKAY);
      axi_wr(OFS_TC_HI, tc[15:8], RESP_OKAY);
      axi_wr(OFS_MISC, 8'h03, RESP_OKAY);
      measure(int'(tc) + 2);
      axi_wr(OFS_MISC, 8'h02, RESP_OKAY);
      @(negedge aclk);
      b0 = bout;
      z0 = bzero;
      fl = 1'b0;
      repeat (20) begin
        @(negedge aclk);
        if (bout !== b0 || bzero !== z0) fl = 1'b1;
      end
      chk(fl, 1'b0);
    end
    $display("test peripheral clock generator done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    @(negedge aclk);
    chk(bzero, 1'b1);
    axi_wr(OFS_TC_LO, 8'h01, RESP_OKAY);
    axi_wr(OFS_MISC, 8'h01, RESP_OKAY);
    measure(12);
    // pin period is four cycles, so forty cycles hold ten rising edges
    k = 0;
    repeat (40) begin
      @(negedge aclk);
      k += int'(rxs);
    end
    chk(32'(k), 32'h0000000a);
    $display("test pin clock generator done");
    tally_and_finish();
  end
endmodule : tb
